// ### sap_stereo_audio_fifo_port.sv
// Purpose: Stereo audio FIFO port with AXI4-Lite register access
// Assumes: Codec side is a valid/ready sample stream per direction
// Notes: Serial framing toward the codec lives outside this block
//
// Register access over AXI4-Lite was decided locally.

`timescale 1ns/1ps
`default_nettype none

module sap_stereo_audio_fifo_port #(
	parameter int DATA_W = 24,
	parameter int DEPTH = 128,
	parameter bit HAS_IN = 1'b1,
	parameter bit HAS_OUT = 1'b1
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// AXI4-Lite write address
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	// AXI4-Lite write data
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	// AXI4-Lite write response
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// AXI4-Lite read address
	input wire logic [3:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	// AXI4-Lite read data
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Codec capture stream (left and right arrive together)
	input wire logic [DATA_W-1:0] i_cap_left,
	input wire logic [DATA_W-1:0] i_cap_right,
	input wire logic i_cap_valid,
	output logic o_cap_ready,
	// Codec playback stream
	output logic [DATA_W-1:0] o_play_left,
	output logic [DATA_W-1:0] o_play_right,
	output logic o_play_valid,
	input wire logic i_play_ready,
	// Interrupt request
	output logic o_irq
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [CW-1:0] THRESH = CW'((DEPTH * 3 + 3) / 4);

	// ==========================================================
	// Reset synchroniser
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ==========================================================
	// Control register
	sap_pkg::sap_ctrl_t ctrl_q;
	sap_pkg::sap_ctrl_t ctrl_d;

	// ==========================================================
	// AXI write path: latch address and data independently
	logic aw_full_q;
	logic w_full_q;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic awready_q;
	logic wready_q;

	wire aw_take = i_awvalid && awready_q;
	wire w_take = i_wvalid && wready_q;
	wire wr_fire = aw_full_q && w_full_q && !bvalid_q;
	wire [1:0] wr_sel = aw_addr_q[3:2];
	wire wr_ctrl = wr_fire && (wr_sel == sap_pkg::SAP_OFF_CTRL[3:2]);
	wire wr_left = wr_fire && (wr_sel == sap_pkg::SAP_OFF_LEFT[3:2]);
	wire wr_right = wr_fire && (wr_sel == sap_pkg::SAP_OFF_RIGHT[3:2]);
	wire wr_bad = wr_fire && (wr_sel == sap_pkg::SAP_OFF_LEVEL[3:2]);

	always_ff @(posedge i_sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= sap_pkg::SAP_RESP_OKAY;
		end
		else
		begin
			if (aw_take)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= i_awaddr;
			end
			if (w_take)
			begin
				w_full_q <= 1'b1;
				w_data_q <= i_wdata;
				w_strb_q <= i_wstrb;
			end
			if (wr_fire)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= wr_bad ? sap_pkg::SAP_RESP_SLVERR
					: sap_pkg::SAP_RESP_OKAY;
			end
			else if (bvalid_q && i_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Control update honours byte lane 0; upper bits are reserved
	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl && w_strb_q[0])
			ctrl_d = sap_pkg::sap_ctrl_t'(w_data_q[3:0]);
	end

	always_ff @(posedge i_sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
			ctrl_q <= sap_pkg::sap_ctrl_t'(sap_pkg::SAP_CTRL_RESET);
		else
			ctrl_q <= ctrl_d;
	end

	// ==========================================================
	// Read request decode
	logic ar_full_q;
	logic [3:0] ar_addr_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic arready_q;

	wire ar_take = i_arvalid && arready_q;
	wire rd_fire = ar_full_q && !rvalid_q;
	wire [1:0] rd_sel = ar_addr_q[3:2];
	wire rd_left = rd_fire && (rd_sel == sap_pkg::SAP_OFF_LEFT[3:2]);
	wire rd_right = rd_fire && (rd_sel == sap_pkg::SAP_OFF_RIGHT[3:2]);

	// ==========================================================
	// Four FIFOs: 0 left in, 1 right in, 2 left out, 3 right out
	logic [3:0] push;
	logic [3:0] pop;
	logic [3:0] clr;
	logic [DATA_W-1:0] push_data [4];
	logic [DATA_W-1:0] head [4];
	logic [CW-1:0] count [4];
	logic [3:0] full;
	logic [3:0] empty;

	wire cap_ok = !full[0] && !full[1] && !ctrl_q.clr_in;
	wire play_have = !empty[2] && !empty[3] && !ctrl_q.clr_out;
	wire play_take = o_play_valid && i_play_ready;
	wire play_load = play_have && (!o_play_valid || i_play_ready);

	// Input side fed by codec, drained by reads; output the reverse
	assign push[0] = HAS_IN && i_cap_valid && o_cap_ready;
	assign push[1] = HAS_IN && i_cap_valid && o_cap_ready;
	assign push[2] = HAS_OUT && wr_left && w_strb_q != 4'h0;
	assign push[3] = HAS_OUT && wr_right && w_strb_q != 4'h0;
	assign pop[0] = rd_left && !empty[0];
	assign pop[1] = rd_right && !empty[1];
	assign pop[2] = play_load;
	assign pop[3] = play_load;
	assign clr = {ctrl_q.clr_out, ctrl_q.clr_out,
		ctrl_q.clr_in, ctrl_q.clr_in};
	assign push_data[0] = i_cap_left;
	assign push_data[1] = i_cap_right;
	assign push_data[2] = w_data_q[DATA_W-1:0];
	assign push_data[3] = w_data_q[DATA_W-1:0];

	// One circular buffer per channel
	for (genvar g = 0; g < 4; g++)
	begin : g_fifo
		logic [DATA_W-1:0] mem [DEPTH];
		logic [AW-1:0] wp_q;
		logic [AW-1:0] rp_q;
		logic [CW-1:0] cnt_q;
		wire do_push = push[g] && !full[g] && !clr[g];
		wire do_pop = pop[g] && !empty[g] && !clr[g];

		assign full[g] = (cnt_q == DEPTH_C);
		assign empty[g] = (cnt_q == '0);
		assign head[g] = mem[rp_q];
		assign count[g] = cnt_q;

		always_ff @(posedge i_sys_clk)
		begin
			if (do_push)
				mem[wp_q] <= push_data[g];
		end

		// Pointers and fill count; clear holds the FIFO empty
		always_ff @(posedge i_sys_clk or negedge rst_n_q)
		begin
			if (!rst_n_q)
			begin
				wp_q <= '0;
				rp_q <= '0;
				cnt_q <= '0;
			end
			else if (clr[g])
			begin
				wp_q <= '0;
				rp_q <= '0;
				cnt_q <= '0;
			end
			else
			begin
				if (do_push)
					wp_q <= AW'(wp_q + 1'b1);
				if (do_pop)
					rp_q <= AW'(rp_q + 1'b1);
				if (do_push && !do_pop)
					cnt_q <= CW'(cnt_q + 1'b1);
				else if (do_pop && !do_push)
					cnt_q <= CW'(cnt_q - 1'b1);
			end
		end
	end

	// ==========================================================
	// Interrupt conditions
	wire [CW-1:0] free_l = CW'(DEPTH_C - count[2]);
	wire [CW-1:0] free_r = CW'(DEPTH_C - count[3]);
	wire rx_pend = HAS_IN && (count[0] >= THRESH || count[1] >= THRESH);
	wire tx_pend = HAS_OUT && (free_l >= THRESH || free_r >= THRESH);
	wire irq_d = (rx_pend && ctrl_q.rx_irq_en) ||
		(tx_pend && ctrl_q.tx_irq_en);

	// Fields saturate at 255 to fit their byte
	function automatic logic [7:0] sat8(input logic [CW-1:0] v);
		logic [31:0] w;
		w = 32'(v);
		sat8 = (w > 32'hFF) ? 8'hFF : w[7:0];
	endfunction

	wire [31:0] ctrl_rd = {22'h0, tx_pend, rx_pend, 4'h0,
		ctrl_q};
	wire [31:0] level_rd = {sat8(HAS_OUT ? free_l : '0),
		sat8(HAS_OUT ? free_r : '0), sat8(count[0]),
		sat8(count[1])};
	wire [31:0] left_rd = 32'(head[0]);
	wire [31:0] right_rd = 32'(head[1]);

	logic [31:0] rd_mux;
	always_comb
	begin
		case (rd_sel)
			2'h0: rd_mux = ctrl_rd;
			2'h1: rd_mux = level_rd;
			2'h2: rd_mux = empty[0] ? 32'h0 : left_rd;
			2'h3: rd_mux = empty[1] ? 32'h0 : right_rd;
			default: rd_mux = 32'h0;
		endcase
	end

	// ==========================================================
	// AXI read path
	always_ff @(posedge i_sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			ar_full_q <= 1'b0;
			ar_addr_q <= 4'h0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= sap_pkg::SAP_RESP_OKAY;
		end
		else
		begin
			if (ar_take)
			begin
				ar_full_q <= 1'b1;
				ar_addr_q <= i_araddr;
			end
			if (rd_fire)
			begin
				ar_full_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_mux;
				rresp_q <= sap_pkg::SAP_RESP_OKAY;
			end
			else if (rvalid_q && i_rready)
				rvalid_q <= 1'b0;
		end
	end

	// ==========================================================
	// Playback register, capture ready and interrupt flop
	logic play_v_q;
	logic [DATA_W-1:0] play_l_q;
	logic [DATA_W-1:0] play_r_q;
	logic cap_rdy_q;
	logic irq_q;

	always_ff @(posedge i_sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			play_v_q <= 1'b0;
			play_l_q <= '0;
			play_r_q <= '0;
			cap_rdy_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			if (play_load)
			begin
				play_v_q <= 1'b1;
				play_l_q <= head[2];
				play_r_q <= head[3];
			end
			else if (play_take || ctrl_q.clr_out)
				play_v_q <= 1'b0;
			cap_rdy_q <= HAS_IN && cap_ok && !o_cap_ready;
			irq_q <= irq_d;
		end
	end

	// Next state of the holding flags, so the readies can be flops
	wire aw_full_n = !wr_fire && (aw_take || aw_full_q);
	wire w_full_n = !wr_fire && (w_take || w_full_q);
	wire bvalid_n = wr_fire || (bvalid_q && !i_bready);
	wire ar_full_n = !rd_fire && (ar_take || ar_full_q);
	wire rvalid_n = rd_fire || (rvalid_q && !i_rready);

	// Registered readies: high when their own channel holds nothing and no answer waits
	always_ff @(posedge i_sys_clk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
		end
		else
		begin
			awready_q <= !aw_full_n && !bvalid_n;
			wready_q <= !w_full_n && !bvalid_n;
			arready_q <= !ar_full_n && !rvalid_n;
		end
	end

	assign o_awready = awready_q;
	assign o_wready = wready_q;
	assign o_bvalid = bvalid_q;
	assign o_bresp = bresp_q;
	assign o_arready = arready_q;
	assign o_rvalid = rvalid_q;
	assign o_rdata = rdata_q;
	assign o_rresp = rresp_q;
	assign o_play_valid = play_v_q;
	assign o_play_left = play_l_q;
	assign o_play_right = play_r_q;
	assign o_cap_ready = cap_rdy_q;
	assign o_irq = irq_q;

endmodule

`default_nettype wire

// ### sap_pkg.sv
// Purpose: Constants and types for the stereo audio FIFO port
// Assumes: 32-bit AXI4-Lite register access, 250 MHz system clock
// Notes: Register map, field positions and types below

package sap_pkg;

	// ==========================================================
	// Register map
	localparam logic [3:0] SAP_OFF_CTRL = 4'h0;
	localparam logic [3:0] SAP_OFF_LEVEL = 4'h4;
	localparam logic [3:0] SAP_OFF_LEFT = 4'h8;
	localparam logic [3:0] SAP_OFF_RIGHT = 4'hC;

	// ==========================================================
	// Control field positions
	localparam int SAP_BIT_RX_IRQ_EN = 0;
	localparam int SAP_BIT_TX_IRQ_EN = 1;
	localparam int SAP_BIT_CLR_IN = 2;
	localparam int SAP_BIT_CLR_OUT = 3;
	localparam int SAP_BIT_RX_PEND = 8;
	localparam int SAP_BIT_TX_PEND = 9;

	// Level field positions
	localparam int SAP_POS_LEFT_OUT_FREE = 24;
	localparam int SAP_POS_RIGHT_OUT_FREE = 16;
	localparam int SAP_POS_LEFT_IN_COUNT = 8;
	localparam int SAP_POS_RIGHT_IN_COUNT = 0;

	// Reset values
	localparam logic [3:0] SAP_CTRL_RESET = 4'h0;

	// AXI responses
	localparam logic [1:0] SAP_RESP_OKAY = 2'h0;
	localparam logic [1:0] SAP_RESP_SLVERR = 2'h2;

	// ==========================================================
	// Writable control bits
	typedef struct packed {
		logic clr_out;
		logic clr_in;
		logic tx_irq_en;
		logic rx_irq_en;
	} sap_ctrl_t;

	// One stereo sample pair toward the codec
	typedef struct packed {
		logic [31:0] left;
		logic [31:0] right;
	} sap_pair_t;

endpackage

// ### sap_port_assertions.sv
// Purpose: Port checks for the stereo audio FIFO port
// Assumes: One clock, active-low reset
// Notes: Bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module sap_port_checker #(
	parameter int DATA_W = 24
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// Register bus
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	// Codec streams
	input wire logic [DATA_W-1:0] o_play_left,
	input wire logic o_play_valid,
	input wire logic i_play_ready,
	input wire logic o_cap_ready
);
	// ====================
	// Address of the write in flight
	logic [3:0] aw_q;
	always_ff @(posedge i_sys_clk)
	begin
		if (i_awvalid && o_awready)
			aw_q <= i_awaddr;
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	// ====================
	// Register bus answers and codec stream handshakes
	a_level_refused: assert property (
		o_bvalid && aw_q == 4'h4 |-> o_bresp == 2'h2)
		else $error("level write not refused");
	a_write_okay: assert property (
		o_bvalid && aw_q != 4'h4 |-> o_bresp == 2'h0)
		else $error("register write refused");
	a_write_answer: assert property (
		i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write answer late");
	a_bresp_holds: assert property (
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write answer dropped");
	a_read_answer: assert property (
		i_arvalid && o_arready |=> !o_rvalid ##1 o_rvalid)
		else $error("read answer timing");
	a_rdata_holds: assert property (
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	a_read_okay: assert property (
		o_rvalid |-> o_rresp == 2'h0 && !o_arready)
		else $error("read response wrong");
	a_pair_holds: assert property (
		o_play_valid && !i_play_ready |=> o_play_valid
		&& $stable(o_play_left))
		else $error("playback pair changed");
	a_cap_spacing: assert property (
		o_cap_ready |=> !o_cap_ready)
		else $error("capture ready too often");
endmodule
bind sap_stereo_audio_fifo_port sap_port_checker #(.DATA_W(DATA_W))
	u_sap_port_checker (.*);
`default_nettype wire

// ### sap_codec_model.sv
// Purpose: Behavioural codec facing the port's sample streams
// Assumes: Bench sets stall and slow between transfers
// Notes: Released capture lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sap_codec_model #(
	parameter int DATA_W = 24
) (
	// Clock
	input wire logic i_sys_clk,
	// Capture stream toward the port
	output logic [DATA_W-1:0] o_cap_left,
	output logic [DATA_W-1:0] o_cap_right,
	output logic o_cap_valid,
	input wire logic i_cap_ready,
	// Playback stream from the port
	input wire logic [DATA_W-1:0] i_play_left,
	input wire logic [DATA_W-1:0] i_play_right,
	input wire logic i_play_valid,
	output logic o_play_ready
);
	// Stall holds ready low, slow halves the take rate
	logic stall = 1'b1;
	logic slow = 1'b0;
	logic [DATA_W-1:0] got_l[$];
	logic [DATA_W-1:0] got_r[$];
	initial
	begin
		o_cap_valid = 1'b0;
		o_cap_left = '0;
		o_cap_right = '0;
		o_play_ready = 1'b0;
	end
	// Offer n pairs, each held until the port takes it
	task automatic send(input int n, input logic [DATA_W-1:0] base);
		@(posedge i_sys_clk);
		for (int k = 0; k < n; k++)
		begin
			o_cap_valid <= 1'b1;
			o_cap_left <= base + DATA_W'(k);
			o_cap_right <= ~(base + DATA_W'(k));
			do
				@(posedge i_sys_clk);
			while (!i_cap_ready);
		end
		o_cap_valid <= 1'b0;
		o_cap_left <= ~o_cap_left;
		o_cap_right <= ~o_cap_right;
	endtask
	// Take whole pairs only
	always @(posedge i_sys_clk)
	begin
		if (o_play_ready && i_play_valid)
		begin
			got_l.push_back(i_play_left);
			got_r.push_back(i_play_right);
		end
		o_play_ready <= !stall && !(slow && o_play_ready);
	end
endmodule
`default_nettype wire

// ### tb_stereo_audio_fifo_port.sv
// Purpose: Self-checking bench for the stereo audio FIFO port
// Assumes: Eight-entry FIFOs, 24-bit samples
// Notes: Codec side is the behavioural model
`timescale 1ns/1ps
`default_nettype none
module tb_stereo_audio_fifo_port;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [3:0] i_awaddr = 4'h0;
	logic [3:0] i_araddr = 4'h0;
	logic [3:0] i_wstrb = 4'hF;
	logic [31:0] i_wdata = 32'h0;
	logic i_awvalid = 1'b0;
	logic i_wvalid = 1'b0;
	logic i_bready = 1'b0;
	logic i_arvalid = 1'b0;
	logic i_rready = 1'b0;
	logic [23:0] i_cap_left, i_cap_right, o_play_left, o_play_right;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
	logic i_cap_valid, o_cap_ready, o_play_valid, i_play_ready;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	int bad_count = 0;
	int checks_done = 0;
	sap_stereo_audio_fifo_port #(.DEPTH(8))
		u_sap_stereo_audio_fifo_port (.*);
	sap_codec_model u_sap_codec_model (
		.i_sys_clk(i_sys_clk),
		.o_cap_left(i_cap_left),
		.o_cap_right(i_cap_right),
		.o_cap_valid(i_cap_valid),
		.i_cap_ready(o_cap_ready),
		.i_play_left(o_play_left),
		.i_play_right(o_play_right),
		.i_play_valid(o_play_valid),
		.o_play_ready(i_play_ready)
	);
	// 250 MHz clock
	initial
	begin
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	// ====================
	// Compare and bus tasks
	task automatic chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e)
		begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ap;
		logic wp;
		ap = 1'b1;
		wp = 1'b1;
		@(posedge i_sys_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do
		begin
			@(posedge i_sys_clk);
			ap = ap && !o_awready;
			wp = wp && !o_wready;
			i_awvalid <= ap;
			i_wvalid <= wp;
		end
		while (ap || wp);
		while (!o_bvalid)
			@(posedge i_sys_clk);
		chk("bresp", {30'h0, er}, {30'h0, o_bresp});
		i_bready <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] e,
		input string n);
		@(posedge i_sys_clk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do
			@(posedge i_sys_clk);
		while (!o_arready);
		i_arvalid <= 1'b0;
		do
			@(posedge i_sys_clk);
		while (!o_rvalid);
		chk(n, e, o_rdata);
		i_rready <= 1'b0;
	endtask
	task automatic drain(input int n);
		for (int i = 0; i < 200 && u_sap_codec_model.got_l.size() < n; i++)
			@(posedge i_sys_clk);
		chk("pairs", n, u_sap_codec_model.got_l.size());
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		repeat (20000) @(posedge i_sys_clk);
		bad_count++;
		stop_test();
	end
	// ====================
	// Test sequence
	initial
	begin
		repeat (20) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_sys_clk);
		rc(4'h0, 32'h00000200, "ctrl");
		rc(4'h4, 32'h08080000, "level");
		chk("irq", 32'h0, {31'h0, o_irq});
		wr(4'h4, 32'hFFFFFFFF, 2'h2);
		rc(4'h4, 32'h08080000, "level");
		wr(4'h0, 32'h3, 2'h0);
		rc(4'h0, 32'h00000203, "ctrl");
		chk("irq", 32'h1, {31'h0, o_irq});
		wr(4'h0, 32'h1, 2'h0);
		@(posedge i_sys_clk);
		chk("irq", 32'h0, {31'h0, o_irq});
		$display("test registers done");
		for (int k = 0; k < 3; k++)
			wr(4'h8, 32'h00A1B200 + k, 2'h0);
		rc(4'h4, 32'h05080000, "level");
		chk("play", 32'h0, {31'h0, o_play_valid});
		for (int k = 0; k < 3; k++)
			wr(4'hC, 32'h0, 2'h0);
		u_sap_codec_model.slow <= 1'b1;
		u_sap_codec_model.stall <= 1'b0;
		drain(3);
		for (int k = 0; k < 3; k++)
			chk("left", 32'h00A1B200 + k, u_sap_codec_model.got_l[k]);
		chk("right", 32'h0, u_sap_codec_model.got_r[2]);
		$display("test pairing done");
		u_sap_codec_model.stall <= 1'b1;
		for (int k = 0; k < 9; k++)
			wr(4'h8, 32'h00C00000 + k, 2'h0);
		rc(4'h4, 32'h00080000, "level");
		for (int k = 0; k < 8; k++)
			wr(4'hC, 32'h1, 2'h0);
		u_sap_codec_model.stall <= 1'b0;
		drain(11);
		for (int k = 0; k < 8; k++)
			chk("kept", 32'h00C00000 + k, u_sap_codec_model.got_l[3 + k]);
		u_sap_codec_model.stall <= 1'b1;
		wr(4'h8, 32'h5, 2'h0);
		wr(4'h8, 32'h6, 2'h0);
		rc(4'h4, 32'h06080000, "level");
		wr(4'h0, 32'h9, 2'h0);
		rc(4'h4, 32'h08080000, "level");
		chk("play", 32'h0, {31'h0, o_play_valid});
		wr(4'h0, 32'h1, 2'h0);
		$display("test output fifo done");
		u_sap_codec_model.stall <= 1'b0;
		fork
			u_sap_codec_model.send(6, 24'h300000);
			wr(4'h8, 32'h00E00000, 2'h0);
		join
		wr(4'hC, 32'h2, 2'h0);
		drain(12);
		rc(4'h4, 32'h08080606, "level");
		rc(4'h0, 32'h00000301, "ctrl");
		chk("irq", 32'h1, {31'h0, o_irq});
		for (int k = 0; k < 6; k++)
		begin
			if (k == 1)
				rc(4'h0, 32'h00000201, "ctrl");
			rc(4'h8, 32'h00300000 + k, "left");
			rc(4'hC, 32'h00CFFFFF - k, "right");
		end
		rc(4'h8, 32'h0, "empty");
		rc(4'h4, 32'h08080000, "level");
		u_sap_codec_model.send(3, 24'h100000);
		wr(4'h0, 32'h4, 2'h0);
		rc(4'h4, 32'h08080000, "level");
		rc(4'h0, 32'h00000204, "ctrl");
		$display("test input fifo done");
		stop_test();
	end
endmodule
`default_nettype wire
